//--- rtl/hpb_host_port.sv
// Purpose: ISA-style index/data host port with buffered SRAM, tx slots, rx ring
// Assumes: host strobes are asynchronous and slow against clk_sys (40 MHz)
// Notes: writes act at strobe release, reads present data at strobe start
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module hpb_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys, // system clock
    input wire logic rst, // sync reset
    input wire logic [WIDTH-1:0] inData, // write data
    input wire logic inValid, // write request
    output logic inReady, // room available
    output logic [WIDTH-1:0] outData, // head data
    output logic outValid, // not empty
    input wire logic outReady // head taken
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic push, pop;
    assign inReady = (wrPtr - rdPtr) != (PW+1)'(DEPTH);
    assign outValid = wrPtr != rdPtr;
    assign outData = store[rdPtr[PW-1:0]];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    always_comb begin
        next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
        end
        if (push) begin
            store[wrPtr[PW-1:0]] <= inData;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
module hpb_host_port import hpb_pkg::*; (
    input wire logic clk_sys, // system clock
    input wire logic rst, // sync reset
    input wire logic [9:0] hostAddr, // host io address
    input wire logic hostCmd, // port select
    input wire logic hostRd_n, // read strobe
    input wire logic hostWr_n, // write strobe
    input wire logic [31:0] hostDataIn, // data bus in
    output logic [31:0] hostDataOut, // data bus out
    output logic hostDataOe, // drive data bus
    input wire logic [1:0] busMode, // 8/16/32-bit access
    input wire logic [2:0] ioStrap, // base strap
    input wire logic [2:0] eeBase, // base from eeprom
    input wire logic eeBaseValid, // eeprom base loaded
    output logic txCrcOff, // no crc append
    output logic txPadOff, // no padding
    output logic [7:0] txData, // tx byte
    output logic txLast, // last tx byte
    output logic txValid, // tx byte valid
    input wire logic txReady, // tx byte taken
    input wire logic [7:0] rxData, // rx byte
    input wire logic rxLast, // last rx byte
    input wire logic [7:0] rxStatus, // rx packet status
    input wire logic rxValid, // rx byte valid
    output logic rxReady // rx byte accepted
);
    logic [7:0] mem [MEM_BYTES];
    logic [53:0] pinMeta, pinSync;
    logic [2:0] strapS;
    logic [9:0] addrS;
    logic cmdS, rdS, wrS, eeValS;
    logic [31:0] dataS;
    logic [1:0] modeS;
    logic [2:0] eeS;
    logic rdPrev, wrPrev, rdStart, rdEnd, wrEnd, sel;
    logic [2:0] baseSel;
    logic [9:0] baseAddr;
    logic [AW-1:0] step, mask;

    // two-stage sync of every host bus, mode and base input (not rst, tx or rx inputs)
    always_ff @(posedge clk_sys) begin
        pinMeta <= {hostAddr, hostCmd, hostRd_n, hostWr_n, hostDataIn, busMode,
                    eeBase, eeBaseValid, ioStrap};
        pinSync <= pinMeta;
    end
    assign {addrS, cmdS, rdS, wrS, dataS, modeS, eeS, eeValS, strapS} = pinSync;

    // base latched from strap at reset, replaced by eeprom value
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            baseSel <= strapS;
        end else if (eeValS) begin
            baseSel <= eeS;
        end
        rdPrev <= rdS;
        wrPrev <= wrS;
    end
    assign baseAddr = IO_BASE_LO + {3'h0, baseSel, 4'h0};
    assign sel = addrS[9:4] == baseAddr[9:4];
    assign rdStart = ~rdS & rdPrev & sel;
    assign rdEnd = rdS & ~rdPrev;
    assign wrEnd = wrS & ~wrPrev & sel;
    assign step = (modeS == MODE_8) ? 14'h0001 : (modeS == MODE_16) ? 14'h0002 : 14'h0004;
    assign mask = step - 14'h0001;

    function automatic logic [31:0] memWord(input logic [AW-1:0] a);
        memWord = {mem[a + 14'h0003], mem[a + 14'h0002], mem[a + 14'h0001], mem[a]};
    endfunction

    function automatic logic [AW-1:0] ringInc(input logic [AW-1:0] a,
                                             input logic [AW-1:0] n);
        logic [AW:0] s;
        s = {1'b0, a} + {1'b0, n};
        ringInc = s[AW] ? RX_START + s[AW-1:0] : s[AW-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // host-facing, transmit and receive control state
    logic [7:0] index, next_index, ctrl, next_ctrl, interrupt_mask_register, next_imr;
    logic [7:0] stat1, next_stat1, stat2, next_stat2;
    logic [15:0] txLen, next_txLen, txRem, next_txRem, rxCnt, next_rxCnt;
    logic [AW-1:0] memAddr, next_memAddr, txAddr, next_txAddr;
    logic [AW-1:0] rxPkt, next_rxPkt, rxWr, next_rxWr;
    logic [31:0] dataBuf, next_dataBuf, next_hostDataOut;
    logic loadPend, next_loadPend, rdActive, next_rdActive;
    logic rdIsMem, next_rdIsMem, rdAdv, next_rdAdv;
    logic slotTwo, next_slotTwo;
    logic [1:0] hdrIdx, next_hdrIdx;
    logic [7:0] rxStat, next_rxStat;
    hpb_tx_e txState, next_txState;
    hpb_rx_e rxState, next_rxState;
    logic hostMemWr, rxWrEn, fifoInReady, fifoPush;
    logic [AW-1:0] rxWAddr;
    logic [7:0] rxWByte, regVal;
    logic [AW:0] sum;
    logic [8:0] fifoOut;

    always_comb begin
        case (index)
            REG_TX_CTRL: regVal = ctrl;
            REG_TX_STAT1: regVal = stat1;
            REG_TX_STAT2: regVal = stat2;
            REG_LEN_LO: regVal = txLen[7:0];
            REG_LEN_HI: regVal = txLen[15:8];
            REG_MADDR_LO: regVal = memAddr[7:0];
            REG_MADDR_HI: regVal = {2'h0, memAddr[AW-1:8]};
            REG_RX_PTR_LO: regVal = rxPkt[7:0];
            REG_RX_PTR_HI: regVal = {2'h0, rxPkt[AW-1:8]};
            REG_IMR: regVal = interrupt_mask_register;
            default: regVal = 8'h00;
        endcase
    end

    assign hostMemWr = wrEnd & cmdS & (index == REG_MWR);
    assign fifoPush = (txState == TX_SEND) && (txRem != 16'h0000);

    always_comb begin
        next_index = index;
        next_ctrl = ctrl;
        next_imr = interrupt_mask_register;
        next_stat1 = stat1;
        next_stat2 = stat2;
        next_txLen = txLen;
        next_txRem = txRem;
        next_txAddr = txAddr;
        next_memAddr = memAddr;
        next_dataBuf = dataBuf;
        next_loadPend = 1'b0;
        next_rdActive = rdActive;
        next_rdIsMem = rdIsMem;
        next_rdAdv = rdAdv;
        next_hostDataOut = hostDataOut;
        next_slotTwo = slotTwo;
        next_txState = txState;
        next_rxState = rxState;
        next_rxPkt = rxPkt;
        next_rxWr = rxWr;
        next_rxCnt = rxCnt;
        next_hdrIdx = hdrIdx;
        next_rxStat = rxStat;
        rxWrEn = 1'b0;
        rxWAddr = rxWr;
        rxWByte = rxData;
        sum = {1'b0, memAddr} + {1'b0, step};
        // prefetch of the word at the current memory address
        if (loadPend) begin
            next_dataBuf = memWord(memAddr);
        end
        // index port and register writes
        if (wrEnd) begin
            if (!cmdS) begin
                next_index = dataS[7:0];
            end else begin
                case (index)
                    REG_TX_CTRL: next_ctrl = dataS[7:0];
                    REG_LEN_LO: next_txLen[7:0] = dataS[7:0];
                    REG_LEN_HI: next_txLen[15:8] = dataS[7:0];
                    REG_IMR: next_imr = dataS[7:0];
                    REG_MADDR_LO: next_memAddr[7:0] = dataS[7:0];
                    REG_MADDR_HI: next_memAddr[AW-1:8] = dataS[AW-9:0];
                    REG_MWR_PRE: next_loadPend = 1'b1;
                    REG_MWR: begin
                        // write area wraps at end of transmit space
                        if (interrupt_mask_register[IMR_WRAP] && memAddr < TX_END && sum >= {1'b0, TX_END}) begin
                            next_memAddr = '0;
                        end else begin
                            next_memAddr = sum[AW-1:0];
                        end
                        next_loadPend = 1'b1;
                    end
                    default: next_index = index;
                endcase
            end
        end
        // reads: present at strobe start, side effect at strobe end
        if (rdStart) begin
            next_rdActive = 1'b1;
            next_rdIsMem = cmdS && (index == REG_MRD || index == REG_MRD_PRE);
            next_rdAdv = cmdS && (index == REG_MRD);
            next_hostDataOut = !cmdS ? {24'h0, index} :
                (index == REG_MRD || index == REG_MRD_PRE) ? dataBuf : {24'h0, regVal};
        end
        if (rdEnd && rdActive) begin
            next_rdActive = 1'b0;
            if (rdIsMem) begin
                next_loadPend = 1'b1;
            end
            if (rdAdv) begin
                if (interrupt_mask_register[IMR_WRAP] && sum[AW]) begin
                    next_memAddr = RX_START + sum[AW-1:0];
                end else begin
                    next_memAddr = sum[AW-1:0];
                end
            end
        end
        // transmit slot engine
        case (txState)
            TX_IDLE: begin
                if (ctrl[CTRL_TXREQ] && txLen != 16'h0000) begin
                    next_txState = TX_SEND;
                    next_txRem = txLen;
                    next_txAddr = slotTwo ? TX_SLOT2_BASE : TX_SLOT1_BASE;
                end
            end
            TX_SEND: begin
                if (fifoPush && fifoInReady) begin
                    next_txRem = txRem - 16'h0001;
                    next_txAddr = txAddr + 14'h0001;
                end else if (txRem == 16'h0000) begin
                    next_txState = TX_IDLE;
                    // a host request landing in the same cycle wins over the clear
                    if (!(wrEnd && cmdS && index == REG_TX_CTRL)) begin
                        next_ctrl[CTRL_TXREQ] = 1'b0;
                    end
                    next_slotTwo = ~slotTwo;
                    if (slotTwo) begin
                        next_stat2 = STAT_DONE;
                    end else begin
                        next_stat1 = STAT_DONE;
                    end
                end
            end
            default: next_txState = TX_IDLE;
        endcase
        // receive ring writer; header goes in after the data
        case (rxState)
            RX_DATA: begin
                if (rxValid) begin
                    rxWrEn = 1'b1;
                    next_rxWr = ringInc(rxWr, 14'h0001);
                    next_rxCnt = rxCnt + 16'h0001;
                    if (rxLast) begin
                        next_rxState = RX_HDR;
                        next_rxStat = rxStatus;
                        next_hdrIdx = 2'h0;
                    end
                end
            end
            RX_HDR: begin
                rxWrEn = 1'b1;
                rxWAddr = ringInc(rxPkt, {12'h000, hdrIdx});
                case (hdrIdx)
                    2'h0: rxWByte = RX_MARK;
                    2'h1: rxWByte = rxStat;
                    2'h2: rxWByte = rxCnt[7:0];
                    default: rxWByte = rxCnt[15:8];
                endcase
                next_hdrIdx = hdrIdx + 2'h1;
                if (hdrIdx == 2'h3) begin
                    next_rxState = RX_DATA;
                    next_rxCnt = '0;
                    // next packet start rounded up to the access width
                    next_rxPkt = ringInc(rxWr, mask) & ~mask;
                    next_rxWr = ringInc(ringInc(rxWr, mask) & ~mask, HDR_BYTES);
                end
            end
            default: next_rxState = RX_DATA;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            index <= '0;
            ctrl <= '0;
            interrupt_mask_register <= '0;
            stat1 <= '0;
            stat2 <= '0;
            txLen <= '0;
            txRem <= '0;
            txAddr <= TX_SLOT1_BASE;
            slotTwo <= 1'b0;
            memAddr <= '0;
            dataBuf <= '0;
            loadPend <= 1'b0;
            rdActive <= 1'b0;
            rdIsMem <= 1'b0;
            rdAdv <= 1'b0;
            hostDataOut <= '0;
            txState <= TX_IDLE;
            rxState <= RX_DATA;
            rxPkt <= RX_START;
            rxWr <= RX_START + HDR_BYTES;
            rxCnt <= '0;
            hdrIdx <= '0;
            rxStat <= '0;
        end else begin
            index <= next_index;
            ctrl <= next_ctrl;
            interrupt_mask_register <= next_imr;
            stat1 <= next_stat1;
            stat2 <= next_stat2;
            txLen <= next_txLen;
            txRem <= next_txRem;
            txAddr <= next_txAddr;
            slotTwo <= next_slotTwo;
            memAddr <= next_memAddr;
            dataBuf <= next_dataBuf;
            loadPend <= next_loadPend;
            rdActive <= next_rdActive;
            rdIsMem <= next_rdIsMem;
            rdAdv <= next_rdAdv;
            hostDataOut <= next_hostDataOut;
            txState <= next_txState;
            rxState <= next_rxState;
            rxPkt <= next_rxPkt;
            rxWr <= next_rxWr;
            rxCnt <= next_rxCnt;
            hdrIdx <= next_hdrIdx;
            rxStat <= next_rxStat;
        end
    end

    // buffer memory: host write lanes plus receive writer
    always_ff @(posedge clk_sys) begin
        for (int lane = 0; lane < 4; lane++) begin
            if (hostMemWr && 14'(lane) < step) begin
                mem[memAddr + 14'(lane)] <= dataS[8*lane +: 8];
            end
        end
        if (rxWrEn) begin
            mem[rxWAddr] <= rxWByte;
        end
    end

    assign hostDataOe = rdActive & ~rdS;
    assign rxReady = rxState == RX_DATA;
    assign txCrcOff = ctrl[CTRL_CRC_OFF];
    assign txPadOff = ctrl[CTRL_PAD_OFF];

    hpb_fifo #(.WIDTH(9), .DEPTH(TX_FIFO_DEPTH)) txFifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .inData({txRem == 16'h0001, mem[txAddr]}),
        .inValid(fifoPush),
        .inReady(fifoInReady),
        .outData(fifoOut),
        .outValid(txValid),
        .outReady(txReady)
    );
    assign txData = fifoOut[7:0];
    assign txLast = fifoOut[8];
endmodule

//--- rtl/hpb_pkg.sv
// Purpose: shared constants for the host port and packet buffer
// Assumes: byte-wide 16 KB buffer memory, 8-bit register index
// Notes: register indices below 0x10 and 0xfc/0xfd are fixed; others chosen
package hpb_pkg;
    localparam int AW = 14;
    localparam int MEM_BYTES = 16384;
    localparam logic [AW-1:0] TX_END = 14'h0c00;
    localparam logic [AW-1:0] RX_START = 14'h0c00;
    localparam logic [AW-1:0] TX_SLOT1_BASE = 14'h0000;
    localparam logic [AW-1:0] TX_SLOT2_BASE = 14'h0600;
    localparam logic [AW-1:0] HDR_BYTES = 14'h0004;
    localparam logic [9:0] IO_BASE_LO = 10'h300;
    localparam logic [7:0] REG_TX_CTRL = 8'h02;
    localparam logic [7:0] REG_TX_STAT1 = 8'h03;
    localparam logic [7:0] REG_TX_STAT2 = 8'h04;
    localparam logic [7:0] REG_RX_PTR_LO = 8'hf4;
    localparam logic [7:0] REG_RX_PTR_HI = 8'hf5;
    localparam logic [7:0] REG_MRD_PRE = 8'hf0;
    localparam logic [7:0] REG_MRD = 8'hf2;
    localparam logic [7:0] REG_MWR_PRE = 8'hf6;
    localparam logic [7:0] REG_MWR = 8'hf8;
    localparam logic [7:0] REG_MADDR_LO = 8'hfa;
    localparam logic [7:0] REG_MADDR_HI = 8'hfb;
    localparam logic [7:0] REG_LEN_LO = 8'hfc;
    localparam logic [7:0] REG_LEN_HI = 8'hfd;
    localparam logic [7:0] REG_IMR = 8'hff;
    localparam int CTRL_TXREQ = 1;
    localparam int CTRL_PAD_OFF = 2;
    localparam int CTRL_CRC_OFF = 3;
    localparam int IMR_WRAP = 7;
    localparam logic [7:0] STAT_DONE = 8'h80;
    localparam logic [7:0] RX_MARK = 8'h01;
    localparam logic [1:0] MODE_8 = 2'h0;
    localparam logic [1:0] MODE_16 = 2'h1;
    localparam int TX_FIFO_DEPTH = 32;
    typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} hpb_tx_e;
    typedef enum logic [0:0] {RX_DATA = 1'b0, RX_HDR = 1'b1} hpb_rx_e;
endpackage

//--- testbench/hpb_host_model.sv
// Purpose: host processor model for the index/data port
// Assumes: strobes 7 clk low, at least 6 clk high
// Notes: undriven data lines carry the inverse of the last value
`timescale 1ns/1ps
module hpb_host_model import hpb_pkg::*; (
    input wire logic clk_sys, // clock
    input wire logic [31:0] hostDataOut, // read data
    output logic [9:0] hostAddr, // io address
    output logic hostCmd, // port select
    output logic hostRd_n, // read strobe
    output logic hostWr_n, // write strobe
    output logic [31:0] hostDataIn // data lines
);
    logic [9:0] base = IO_BASE_LO;
    initial begin
        hostAddr = IO_BASE_LO;
        hostCmd = 1'b0;
        hostRd_n = 1'b1;
        hostWr_n = 1'b1;
        hostDataIn = 32'h0;
    end
    ////////////////////////////////////////
    task automatic access(input logic cmd, input logic wr, input logic [31:0] d,
                          output logic [31:0] q);
        @(posedge clk_sys);
        hostAddr <= {base[9:4], 4'($urandom)};
        hostCmd <= cmd;
        hostDataIn <= wr ? d : ~hostDataIn;
        @(posedge clk_sys);
        hostWr_n <= ~wr;
        hostRd_n <= wr;
        repeat (7) @(posedge clk_sys);
        q = hostDataOut;
        hostWr_n <= 1'b1;
        hostRd_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        hostDataIn <= ~hostDataIn;
    endtask
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] q;
        access(1'b0, 1'b1, {24'h0, idx}, q);
        access(1'b1, 1'b1, {24'h0, v}, q);
    endtask
    task automatic reg_rd(input logic [7:0] idx, output logic [31:0] q);
        access(1'b0, 1'b1, {24'h0, idx}, q);
        access(1'b1, 1'b0, 32'h0, q);
    endtask
endmodule

//--- testbench/hpb_host_port_properties.sv
// Purpose: port checker for hpb_host_port
// Assumes: single clock domain, sync reset
// Notes: bound to every hpb_host_port instance
`timescale 1ns/1ps
module hpb_host_port_chk (
    input wire logic clk_sys, // clock
    input wire logic rst, // reset
    input wire logic hostRd_n, // read strobe
    input wire logic hostWr_n, // write strobe
    input wire logic [31:0] hostDataOut, // read data
    input wire logic hostDataOe, // bus drive
    input wire logic txCrcOff, // crc off
    input wire logic txPadOff, // pad off
    input wire logic [7:0] txData, // tx byte
    input wire logic txLast, // tx last
    input wire logic txValid, // tx valid
    input wire logic txReady, // tx take
    input wire logic rxValid, // rx valid
    input wire logic rxLast, // rx last
    input wire logic rxReady // rx accept
);
    ////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [3:0] wrAge;
    // cycles since the write strobe was last low
    always_ff @(posedge clk_sys) begin
        wrAge <= rst ? 4'hf : !hostWr_n ? 4'h0 : (wrAge == 4'hf) ? wrAge : wrAge + 4'h1;
    end
    a_reset_idle: assert property ($fell(rst) |-> !hostDataOe && !txValid && rxReady
        && !txCrcOff && !txPadOff) else $error("outputs not idle after reset");
    a_oe_cause: assert property (hostDataOe |-> !$past(hostRd_n) || !$past(hostRd_n, 2)
        || !$past(hostRd_n, 3) || !$past(hostRd_n, 4)) else $error("bus driven without read");
    a_oe_release: assert property ($rose(hostRd_n) |-> ##[1:5] !hostDataOe)
        else $error("bus still driven after read");
    a_read_stable: assert property (hostDataOe && $past(hostDataOe) |-> $stable(hostDataOut))
        else $error("read data moved while driven");
    a_ctrl_cause: assert property ($changed(txCrcOff) || $changed(txPadOff) |-> wrAge < 4'h8)
        else $error("tx control changed without host write");
    a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData)
        && $stable(txLast)) else $error("tx byte dropped while stalled");
    a_rx_header: assert property (rxValid && rxReady && rxLast |=> !rxReady [*4] ##1 rxReady)
        else $error("rx header gap not four cycles");
    a_rx_stall_cause: assert property ($fell(rxReady) |-> $past(rxValid && rxLast))
        else $error("rx stalled without packet end");
    c_tx_last: cover property (txValid && txReady && txLast);
    c_rx_end: cover property (rxValid && rxReady && rxLast);
    c_read: cover property ($fell(hostDataOe));
endmodule
bind hpb_host_port hpb_host_port_chk u_chk (.*);

//--- testbench/tb.sv
// Purpose: self-checking bench for hpb_host_port
// Assumes: u_host drives the host bus
// Notes: mem mirrors the buffer memory
`timescale 1ns/1ps
module tb import hpb_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [1:0] busMode = 2'h0;
    logic [2:0] ioStrap = 3'h0;
    logic [2:0] eeBase = 3'h0;
    logic eeBaseValid = 1'b0;
    logic txReady = 1'b0;
    logic rxValid = 1'b0;
    logic rxLast = 1'b0;
    logic [7:0] rxData = 8'h00;
    logic [7:0] rxStatus = 8'h00;
    logic [9:0] hostAddr;
    logic hostCmd, hostRd_n, hostWr_n, hostDataOe, txCrcOff, txPadOff, txLast, txValid, rxReady;
    logic [31:0] hostIn, hostDataIn, hostDataOut;
    logic [7:0] txData;
    logic [7:0] mem [16384];
    int failures = 0;
    int checks = 0;
    int rxPtr = 'hc00;
    bit wrap = 1'b0;
    logic [7:0] ri [6] = '{8'h02, 8'h03, 8'h04, 8'hf4, 8'hf5, 8'h50};
    logic [7:0] re [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h00};
    always #12.5 clk_sys = ~clk_sys;
    assign hostDataIn = hostDataOe ? hostDataOut : hostIn;
    hpb_host_port u_hpb_host_port (.*);
    hpb_host_model u_host (.clk_sys(clk_sys), .hostDataOut(hostDataOut), .hostAddr(hostAddr),
        .hostCmd(hostCmd), .hostRd_n(hostRd_n), .hostWr_n(hostWr_n), .hostDataIn(hostIn));
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp || $isunknown(seen)) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    function automatic int width(logic [1:0] m);
        return (m == 2'h0) ? 1 : (m == 2'h1) ? 2 : 4;
    endfunction
    function automatic int step_addr(int a, int w, bit wr);
        int n;
        n = a + w;
        if (wrap && wr && a < 'hc00 && n >= 'hc00) return 0;
        if (wrap && !wr && n >= 'h4000) return n - 'h3400;
        return n % 'h4000;
    endfunction
    task automatic mem_burst(bit wr, int a, logic [1:0] m, int n);
        logic [31:0] q, d;
        int w;
        w = width(m);
        @(posedge clk_sys);
        busMode <= m;
        u_host.reg_wr(REG_MADDR_LO, a[7:0]);
        u_host.reg_wr(REG_MADDR_HI, {2'h0, a[13:8]});
        if (!wr) u_host.reg_rd(REG_MRD_PRE, q);
        u_host.access(1'b0, 1'b1, {24'h0, wr ? REG_MWR : REG_MRD}, q);
        repeat (n) begin
            d = $urandom;
            u_host.access(1'b1, wr, d, q);
            for (int i = 0; i < w; i++) begin
                if (wr) mem[a + i] = d[8*i +: 8];
                else check({24'h0, q[8*i +: 8]}, {24'h0, mem[a + i]});
            end
            a = step_addr(a, w, wr);
        end
    endtask
    task automatic tx_run(int b, int len, logic [7:0] ctl, logic [7:0] st);
        logic [31:0] q;
        int got, k;
        u_host.reg_wr(REG_LEN_LO, len[7:0]);
        u_host.reg_wr(REG_LEN_HI, len[15:8]);
        u_host.reg_wr(REG_TX_CTRL, ctl | 8'h02);
        repeat (60) @(posedge clk_sys);
        check({30'h0, txCrcOff, txPadOff}, {30'h0, ctl[3], ctl[2]});
        got = 0;
        k = 0;
        while (got < len && k < 5000) begin
            @(posedge clk_sys);
            if ((txValid && txReady) === 1'b1) begin
                check({23'h0, txLast, txData}, {23'h0, got == len - 1, mem[b + got]});
                got++;
            end
            txReady <= 1'($urandom);
            k++;
        end
        if (k == 5000) begin
            failures++;
            final_report();
        end
        @(posedge clk_sys);
        txReady <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check({31'h0, txValid}, 32'h0);
        u_host.reg_rd(st, q);
        check(q, {24'h0, STAT_DONE});
        u_host.reg_rd(REG_TX_CTRL, q);
        check(q, {24'h0, ctl});
    endtask
    task automatic rx_pkt(int len);
        logic [7:0] d;
        int k, w;
        d = 8'($urandom);
        mem[rxPtr + 1] = d;
        @(posedge clk_sys);
        w = width(busMode);
        rxStatus <= d;
        for (int i = 0; i < len; i++) begin
            d = 8'($urandom);
            mem[rxPtr + 4 + i] = d;
            rxData <= d;
            rxValid <= 1'b1;
            rxLast <= (i == len - 1);
            k = 0;
            do begin
                @(negedge clk_sys);
                k++;
            end while (rxReady !== 1'b1 && k < 20);
            if (k == 20) begin
                failures++;
                final_report();
            end
            @(posedge clk_sys);
        end
        rxValid <= 1'b0;
        rxLast <= 1'b0;
        mem[rxPtr] = RX_MARK;
        mem[rxPtr + 2] = 8'(len);
        mem[rxPtr + 3] = 8'(len >> 8);
        rxPtr = (rxPtr + 4 + len + w - 1) / w * w;
        repeat (8) @(posedge clk_sys);
    endtask
    ////////////////////////////////////////
    initial begin
        logic [31:0] q;
        int s;
        s = $urandom(42245);
        s = $urandom % 8;
        @(posedge clk_sys);
        ioStrap <= s[2:0];
        u_host.base = IO_BASE_LO + 10'(s * 16);
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        foreach (ri[i]) begin
            u_host.reg_rd(ri[i], q);
            check(q, {24'h0, re[i]});
        end
        for (int m = 0; m < 3; m++) begin
            mem_burst(1'b1, 'h1000 + m * 'h40, 2'(m), 6);
            mem_burst(1'b0, 'h1000 + m * 'h40, 2'(m), 6);
        end
        mem_burst(1'b1, 'hc00, 2'h0, 10);
        mem_burst(1'b1, 'h3fff, 2'h0, 2);
        u_host.reg_wr(REG_IMR, 8'h80);
        wrap = 1'b1;
        mem_burst(1'b1, 'hbff, 2'h0, 2);
        mem_burst(1'b0, 'h3fff, 2'h0, 2);
        mem_burst(1'b0, 'hbff, 2'h0, 2);
        u_host.reg_wr(REG_IMR, 8'h00);
        wrap = 1'b0;
        mem_burst(1'b0, 'h3fff, 2'h0, 2);
        mem_burst(1'b1, 'h0, 2'h1, 20);
        tx_run('h0, 40, 8'h0c, REG_TX_STAT1);
        mem_burst(1'b1, 'h600, 2'h2, 65);
        tx_run('h600, 'h102, 8'h00, REG_TX_STAT2);
        @(posedge clk_sys);
        busMode <= 2'h1;
        rx_pkt(5);
        rx_pkt(3);
        mem_burst(1'b0, 'hc00, 2'h0, 17);
        @(posedge clk_sys);
        eeBase <= 3'(s + 1);
        eeBaseValid <= 1'b1;
        u_host.base = IO_BASE_LO + 10'((s + 1) % 8 * 16);
        u_host.reg_wr(REG_LEN_LO, 8'h5a);
        u_host.reg_rd(REG_LEN_LO, q);
        check(q, 32'h5a);
        final_report();
    end
endmodule
